/* pkg/clk_start_pkg.sv */
// constants, types and fuse decoders for the clock start-up sequencer
// assumes one 25 MHz clock; fuse bits read 1 when unprogrammed
package clk_start_pkg;
  localparam int unsigned CNT_W = 17;
  localparam logic [7:0] FUSE_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [6:0] FUSE_RESET = 7'h61;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SUT_LSB = 4;
  localparam int unsigned OPT_BIT = 6;
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT = 1;
  localparam int unsigned CTRL_RESTART_BIT = 2;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic [16:0] SRC_258 = 17'h00102;
  localparam logic [16:0] SRC_1K = 17'h00400;
  localparam logic [16:0] SRC_16K = 17'h04000;
  localparam logic [16:0] SRC_32K = 17'h08000;
  localparam logic [16:0] WDT_SHORT = 17'h01000;
  localparam logic [16:0] WDT_LONG = 17'h10000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    MODE_XTAL = 3'b000, MODE_LFXTAL = 3'b001, MODE_EXT_RC = 3'b010,
    MODE_INT_RC = 3'b011, MODE_EXT_CLK = 3'b100
  } mode_t;
  typedef enum logic [2:0] {
    RANGE_NONE = 3'b000, RANGE_0P4 = 3'b001, RANGE_0P9 = 3'b010,
    RANGE_3P0 = 3'b011, RANGE_1_16 = 3'b100
  } range_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_C258 = 3'b001, SRC_C1K = 3'b010,
    SRC_C16K = 3'b011, SRC_C32K = 3'b100
  } src_code_t;
  typedef enum logic [1:0] {WDT_NONE = 2'b00, WDT_S = 2'b01, WDT_L = 2'b10} wdt_code_t;
  typedef enum logic [2:0] {
    ST_LATCH = 3'b000, ST_RESET_WAIT = 3'b001, ST_RUN = 3'b010,
    ST_SLEEP = 3'b011, ST_WAKE_WAIT = 3'b100
  } seq_t;
  typedef struct packed {
    src_code_t src;
    wdt_code_t wdt;
    logic ok;
  } startup_t;

  function automatic mode_t decode_mode(input logic [3:0] sel);
    if (sel >= 4'hA) return MODE_XTAL;
    else if (sel == 4'h9) return MODE_LFXTAL;
    else if (sel >= 4'h5) return MODE_EXT_RC;
    else if (sel >= 4'h1) return MODE_INT_RC;
    else return MODE_EXT_CLK;
  endfunction : decode_mode

  function automatic range_t decode_range(input logic [3:0] sel, input logic opt);
    if (decode_mode(sel) != MODE_XTAL) return RANGE_NONE;
    if (opt == FUSE_PROGRAMMED) return RANGE_1_16;
    case (sel[3:1])
      3'h5: return RANGE_0P4;
      3'h6: return RANGE_0P9;
      default: return RANGE_3P0;
    endcase
  endfunction : decode_range

  function automatic startup_t decode_startup(input logic [3:0] sel, input logic [1:0] startup_time_fuses);
    startup_t r;
    r = '{src: SRC_NONE, wdt: WDT_NONE, ok: 1'b0};
    if (decode_mode(sel) == MODE_XTAL) begin
      r.ok = 1'b1;
      case ({sel[0], startup_time_fuses})
        3'b000: r = '{src: SRC_C258, wdt: WDT_S, ok: 1'b1};
        3'b001: r = '{src: SRC_C258, wdt: WDT_L, ok: 1'b1};
        3'b010: r = '{src: SRC_C1K, wdt: WDT_NONE, ok: 1'b1};
        3'b011: r = '{src: SRC_C1K, wdt: WDT_S, ok: 1'b1};
        3'b100: r = '{src: SRC_C1K, wdt: WDT_L, ok: 1'b1};
        3'b101: r = '{src: SRC_C16K, wdt: WDT_NONE, ok: 1'b1};
        3'b110: r = '{src: SRC_C16K, wdt: WDT_S, ok: 1'b1};
        default: r = '{src: SRC_C16K, wdt: WDT_L, ok: 1'b1};
      endcase
    end else if (decode_mode(sel) == MODE_LFXTAL) begin
      case (startup_time_fuses)
        2'b00: r = '{src: SRC_C1K, wdt: WDT_S, ok: 1'b1};
        2'b01: r = '{src: SRC_C1K, wdt: WDT_L, ok: 1'b1};
        2'b10: r = '{src: SRC_C32K, wdt: WDT_L, ok: 1'b1};
        default: r = '{src: SRC_NONE, wdt: WDT_NONE, ok: 1'b0};
      endcase
    end
    return r;
  endfunction : decode_startup
endpackage : clk_start_pkg

/* pkg/count_if.sv */
// carrier between the sequencer and one edge counter
// assumes both ends share the aclk domain
`timescale 1ns/1ps
`default_nettype none
interface count_if;
  logic start;
  logic [16:0] target;
  logic edge_seen;
  logic done;
  modport ctl (output start, output target, output edge_seen, input done);
  modport cnt (input start, input target, input edge_seen, output done);
endinterface : count_if
`default_nettype wire

/* hdl/edge_counter.sv */
// counts edge pulses up to a target loaded by a start pulse
// assumes edge pulses are already synchronised to aclk
`timescale 1ns/1ps
`default_nettype none
module edge_counter (
  input wire logic aclk,
  input wire logic aresetn,
  count_if.cnt cif
);
  import clk_start_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (cif.start) begin
      s_d.cnt = '0;
      s_d.done = (cif.target == '0);
    end else if (!s_q.done && cif.edge_seen) begin
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.done = (s_d.cnt == cif.target);
    end
    if (!aresetn) begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign cif.done = s_q.done;
endmodule : edge_counter
`default_nettype wire

/* hdl/clock_source_startup_select.sv */
// fuse-driven clock source decode and start-up delay sequencer, AXI4-Lite slave
// assumes watchdog oscillator and selected source arrive as async pins
// How it works
// - four select fuses decode the clock source
// - fuse bit one unprogrammed, zero programmed
// - wake counts selected source cycles before running
// - reset also waits for none, 4096 or 65536 watchdog cycles, counted in parallel with the source cycles
// - factory fuses are select 0001, start-up 10
// - crystal range from select bits and option
// - crystal select bit zero start-up table
// - crystal select bit one start-up table
// - low-frequency crystal table, code 11 reserved
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select #(
  parameter logic [16:0] SRC_CNT_258 = clk_start_pkg::SRC_258,
  parameter logic [16:0] SRC_CNT_1K = clk_start_pkg::SRC_1K,
  parameter logic [16:0] SRC_CNT_16K = clk_start_pkg::SRC_16K,
  parameter logic [16:0] SRC_CNT_32K = clk_start_pkg::SRC_32K,
  parameter logic [16:0] WDT_CNT_SHORT = clk_start_pkg::WDT_SHORT,
  parameter logic [16:0] WDT_CNT_LONG = clk_start_pkg::WDT_LONG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wdt_osc_in,
  input wire logic src_clk_in,
  output logic exec_enable,
  output logic osc_full_swing,
  output clk_start_pkg::range_t crystal_range
);
  import clk_start_pkg::*;

  typedef struct packed {
    logic [6:0] fuse;
    logic swing;
    mode_t mode;
    range_t range;
    logic ok;
    seq_t st;
    logic start;
    logic exec;
    logic [CNT_W-1:0] src_tgt;
    logic [CNT_W-1:0] wdt_tgt;
    logic wdt_m, wdt_s, wdt_p;
    logic src_m, src_s, src_p;
    logic awready, wready, arready, bvalid, rvalid, aw_got, w_got;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  startup_t su;
  count_if src_cif ();
  count_if wdt_cif ();

  function automatic logic [CNT_W-1:0] src_count(input src_code_t c);
    case (c)
      SRC_C258: return SRC_CNT_258;
      SRC_C1K: return SRC_CNT_1K;
      SRC_C16K: return SRC_CNT_16K;
      SRC_C32K: return SRC_CNT_32K;
      default: return '0;
    endcase
  endfunction : src_count

  function automatic logic [CNT_W-1:0] wdt_count(input wdt_code_t c);
    case (c)
      WDT_S: return WDT_CNT_SHORT;
      WDT_L: return WDT_CNT_LONG;
      default: return '0;
    endcase
  endfunction : wdt_count

  assign su = decode_startup(s_q.fuse[SEL_LSB+:4], s_q.fuse[SUT_LSB+:2]);

  always_comb begin
    s_d = s_q;
    // pin synchronisers, third stage only for edge detection
    s_d.wdt_m = wdt_osc_in;
    s_d.wdt_s = s_q.wdt_m;
    s_d.wdt_p = s_q.wdt_s;
    s_d.src_m = src_clk_in;
    s_d.src_s = s_q.src_m;
    s_d.src_p = s_q.src_s;
    s_d.start = 1'b0;
    case (s_q.st)
      ST_LATCH: begin
        s_d.swing = (s_q.fuse[OPT_BIT] == FUSE_PROGRAMMED);
        s_d.mode = decode_mode(s_q.fuse[SEL_LSB+:4]);
        s_d.range = decode_range(s_q.fuse[SEL_LSB+:4], s_q.fuse[OPT_BIT]);
        s_d.ok = su.ok;
        s_d.src_tgt = src_count(su.src);
        s_d.wdt_tgt = wdt_count(su.wdt);
        s_d.start = 1'b1;
        s_d.st = ST_RESET_WAIT;
      end
      ST_RESET_WAIT: begin
        if (!s_q.start && src_cif.done && wdt_cif.done) begin
          s_d.exec = 1'b1;
          s_d.st = ST_RUN;
        end
      end
      ST_WAKE_WAIT: begin
        if (!s_q.start && src_cif.done) begin
          s_d.exec = 1'b1;
          s_d.st = ST_RUN;
        end
      end
      ST_RUN, ST_SLEEP: ;
      default: s_d.st = ST_LATCH;
    endcase
    // write channel: address and data taken in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.awready = 1'b0;
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.wready = 1'b0;
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case ({s_q.awaddr[7:2], 2'b00})
        FUSE_OFS: if (s_q.wstrb[0]) s_d.fuse = s_q.wdata[6:0];
        CTRL_OFS: begin
          if (s_q.wstrb[0] && s_q.wdata[CTRL_SLEEP_BIT] && s_q.st == ST_RUN) begin
            s_d.exec = 1'b0;
            s_d.st = ST_SLEEP;
          end else if (s_q.wstrb[0] && s_q.wdata[CTRL_WAKE_BIT] && s_q.st == ST_SLEEP) begin
            s_d.src_tgt = src_count(su.src);
            s_d.wdt_tgt = '0;
            s_d.start = 1'b1;
            s_d.st = ST_WAKE_WAIT;
          end else if (s_q.wstrb[0] && s_q.wdata[CTRL_RESTART_BIT]) begin
            // soft restart: relatch the stored fuses and rerun both reset delays
            s_d.exec = 1'b0;
            s_d.st = ST_LATCH;
          end
        end
        STATUS_OFS: ;
        default: s_d.bresp = RESP_DECERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        FUSE_OFS: s_d.rdata = {25'h0, s_q.fuse};
        CTRL_OFS: s_d.rdata = 32'h00000000;
        STATUS_OFS: s_d.rdata = {20'h00000, !s_q.ok, s_q.swing,
                                 s_q.range, s_q.mode, s_q.st, s_q.exec};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_DECERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (!aresetn) begin
      s_d = '0;
      s_d.fuse = FUSE_RESET;
      s_d.st = ST_LATCH;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign src_cif.start = s_q.start;
  assign src_cif.target = s_q.src_tgt;
  assign src_cif.edge_seen = s_q.src_s & ~s_q.src_p;
  assign wdt_cif.start = s_q.start;
  assign wdt_cif.target = s_q.wdt_tgt;
  assign wdt_cif.edge_seen = s_q.wdt_s & ~s_q.wdt_p;

  edge_counter u_src_cnt (.aclk(aclk), .aresetn(aresetn), .cif(src_cif));
  edge_counter u_wdt_cnt (.aclk(aclk), .aresetn(aresetn), .cif(wdt_cif));

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign exec_enable = s_q.exec;
  assign osc_full_swing = s_q.swing;
  assign crystal_range = s_q.range;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence reset_start_s;
    s_q.st == ST_LATCH ##1 s_q.start;
  endsequence
  sequence wake_req_s;
    s_q.st == ST_SLEEP ##1 s_q.st == ST_WAKE_WAIT;
  endsequence

  a_release_both_done: assert property (
    $rose(s_q.exec) && $past(s_q.st) == ST_RESET_WAIT |-> $past(src_cif.done && wdt_cif.done))
    else $error("execution released before both delays ended");
  a_exec_held_reset: assert property (
    reset_start_s |-> !s_q.exec throughout (##[0:2] 1'b1))
    else $error("execution ran during reset delay");
  a_wake_no_exec: assert property (
    wake_req_s |-> !s_q.exec [*2])
    else $error("execution ran before wake count");
  a_factory_fuses: assert property (
    $past(!aresetn) |-> s_q.fuse == FUSE_RESET)
    else $error("fuse reset value wrong");
  a_xtal_decode: assert property (
    s_q.st == ST_LATCH && s_q.fuse[3:0] >= 4'hA |=> s_q.mode == MODE_XTAL)
    else $error("crystal select not decoded");
  a_range_full: assert property (
    s_q.st == ST_LATCH && s_q.fuse[3:0] >= 4'hA && !s_q.fuse[OPT_BIT]
    |=> s_q.range == RANGE_1_16 && osc_full_swing)
    else $error("programmed option range wrong");
  a_xtal_258_short: assert property (
    s_q.st == ST_LATCH && s_q.fuse[3:0] == 4'hA && s_q.fuse[5:4] == 2'b00
    |=> s_q.src_tgt == SRC_CNT_258 && s_q.wdt_tgt == WDT_CNT_SHORT)
    else $error("crystal 258 short targets wrong");
  a_xtal_16k_none: assert property (
    s_q.st == ST_LATCH && s_q.fuse[3:0] == 4'hB && s_q.fuse[5:4] == 2'b01
    |=> s_q.src_tgt == SRC_CNT_16K && s_q.wdt_tgt == '0)
    else $error("crystal 16K targets wrong");
  a_lf_reserved: assert property (
    s_q.st == ST_LATCH && s_q.fuse[3:0] == 4'h9 && s_q.fuse[5:4] == 2'b11 |=> !s_q.ok)
    else $error("reserved low-frequency code accepted");
  a_bresp_time: assert property (
    s_q.aw_got && s_q.w_got |=> s_q.bvalid)
    else $error("write response late");
endmodule : clock_source_startup_select
`default_nettype wire

/* tb/clock_source_startup_select_bench.sv */
// self-checking bench for the clock start-up sequencer behind its register bus
// assumes clk_start_pkg, count_if and both design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select_bench;
  import clk_start_pkg::*;
  localparam logic [16:0] C258 = 17'h00003;
  localparam logic [16:0] C1K = 17'h00005;
  localparam logic [16:0] C16K = 17'h00008;
  localparam logic [16:0] C32K = 17'h0000A;
  localparam logic [16:0] WSHORT = 17'h00004;
  localparam logic [16:0] WLONG = 17'h0000C;
  localparam int LIMIT = 20000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic src_clk = 1'h0;
  logic wdt_clk = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, exec, swing;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  range_t crange;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #20 aclk = ~aclk;

  clock_source_startup_select #(
    .SRC_CNT_258(C258), .SRC_CNT_1K(C1K), .SRC_CNT_16K(C16K), .SRC_CNT_32K(C32K),
    .WDT_CNT_SHORT(WSHORT), .WDT_CNT_LONG(WLONG)
  ) i_clock_source_startup_select (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wdt_osc_in(wdt_clk),
    .src_clk_in(src_clk), .exec_enable(exec), .osc_full_swing(swing),
    .crystal_range(crange)
  );

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (!aw && awready === 1'h1) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w && wready === 1'h1) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
      if (aw && w && bvalid === 1'h1) break;
    end
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (ar && rvalid === 1'h1) break;
      if (!ar && arready === 1'h1) begin
        ar = 1'h1;
        arvalid <= 1'h0;
      end
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  // one period on both oscillator pins, long enough for the pin synchronisers;
  // the source pin stands for a slow ceramic resonator
  task automatic pulse;
    @(posedge aclk);
    src_clk <= 1'h1;
    wdt_clk <= 1'h1;
    repeat (4) @(posedge aclk);
    src_clk <= 1'h0;
    wdt_clk <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask : pulse

  // load fuses, restart, count both oscillators until the reset delays end
  task automatic t_restart(input logic [3:0] sel, input logic [1:0] startup_time_fuses, input logic opt,
                           input logic [16:0] ns, input logic [16:0] nw, input range_t rng);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    int i;
    n = (ns > nw) ? int'(ns) : int'(nw);
    wr(FUSE_OFS, {25'h0, opt, startup_time_fuses, sel}, r);
    wr(CTRL_OFS, 32'h4, r);
    chk("restart exec", 32'h0, exec);
    if (n == 0) begin
      repeat (6) @(posedge aclk);
      chk("restart exec", 32'h1, exec);
    end else begin
      for (i = 1; i <= n; i++) begin
        pulse();
        chk("restart exec", {31'h0, i == n}, exec);
      end
    end
    chk("restart range", rng, crange);
    chk("restart swing", {31'h0, !opt}, swing);
    rd(STATUS_OFS, d, r);
    chk("restart unsupported", {31'h0, n == 0}, d[11]);
    $display("test restart sel %h code %h done", sel, startup_time_fuses);
  endtask : t_restart

  task automatic t_defaults;
    logic [31:0] d;
    logic [1:0] r;
    int i;
    i = 0;
    while (exec !== 1'h1 && i < 20) begin
      @(posedge aclk);
      i++;
    end
    chk("exec after reset", 32'h1, exec);
    chk("crystal range", 32'h0, crange);
    chk("full swing", 32'h0, swing);
    rd(FUSE_OFS, d, r);
    chk("fuse reset value", 32'h61, d);
    rd(STATUS_OFS, d, r);
    chk("status mode", 32'h3, d[6:4]);
    chk("status state", 32'h2, d[3:1]);
    chk("status option", 32'h0, d[10]);
    chk("status unsupported", 32'h1, d[11]);
    rd(8'h0C, d, r);
    chk("unmapped rresp", RESP_DECERR, r);
    chk("unmapped rdata", 32'h0, d);
    wr(8'h0C, 32'hFFFFFFFF, r);
    chk("unmapped bresp", RESP_DECERR, r);
    rd(CTRL_OFS, d, r);
    chk("ctrl read", 32'h0, d);
    $display("test defaults done");
  endtask : t_defaults

  // sleep, load new fuses, wake and count source edges until release
  task automatic t_wake(input logic [3:0] sel, input logic [1:0] startup_time_fuses, input logic [16:0] n);
    logic [31:0] d;
    logic [1:0] r;
    int i;
    wr(CTRL_OFS, 32'h1, r);
    rd(STATUS_OFS, d, r);
    chk("sleep state", 32'h3, d[3:1]);
    chk("sleep exec", 32'h0, exec);
    wr(FUSE_OFS, {25'h0, 1'h1, startup_time_fuses, sel}, r);
    chk("fuse bresp", RESP_OKAY, r);
    wr(CTRL_OFS, 32'h2, r);
    if (n == 17'h0) begin
      repeat (6) @(posedge aclk);
      chk("wake exec", 32'h1, exec);
    end else begin
      for (i = 1; i <= int'(n); i++) begin
        pulse();
        chk("wake exec", {31'h0, i == int'(n)}, exec);
      end
    end
    $display("test wake sel %h code %h done", sel, startup_time_fuses);
  endtask : t_wake

  task automatic t_wake_in_run;
    logic [31:0] d;
    logic [1:0] r;
    wr(CTRL_OFS, 32'h2, r);
    rd(STATUS_OFS, d, r);
    chk("run state kept", 32'h2, d[3:1]);
    chk("run exec kept", 32'h1, exec);
    $display("test wake in run done");
  endtask : t_wake_in_run

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_defaults();
    t_restart(4'hA, 2'b00, 1'h1, C258, WSHORT, RANGE_0P4);
    t_restart(4'hA, 2'b01, 1'h1, C258, WLONG, RANGE_0P4);
    t_restart(4'hC, 2'b11, 1'h1, C1K, WSHORT, RANGE_0P9);
    t_restart(4'hE, 2'b10, 1'h1, C1K, 17'h0, RANGE_3P0);
    t_restart(4'hB, 2'b01, 1'h0, C16K, 17'h0, RANGE_1_16);
    t_restart(4'hB, 2'b10, 1'h1, C16K, WSHORT, RANGE_0P4);
    t_restart(4'h9, 2'b10, 1'h1, C32K, WLONG, RANGE_NONE);
    t_restart(4'h9, 2'b11, 1'h1, 17'h0, 17'h0, RANGE_NONE);
    t_wake(4'hA, 2'b00, C258);
    t_wake(4'hA, 2'b11, C1K);
    t_wake(4'hB, 2'b00, C1K);
    t_wake(4'hB, 2'b01, C16K);
    t_wake(4'hF, 2'b11, C16K);
    t_wake(4'h9, 2'b10, C32K);
    t_wake(4'h9, 2'b11, 17'h0);
    t_wake(4'h5, 2'b00, 17'h0);
    t_wake_in_run();
    conclude();
  end
endmodule : clock_source_startup_select_bench
`default_nettype wire
